// ### rtl/apdu_transport_layer.sv
// Card-side transport layer for byte and block protocol command exchanges
//
// Notes on behaviour
// (RULE_01) Case 3 command data length is 1 to 255, command passed unchanged; the code takes a P3 of zero as 256 data bytes.
// (RULE_02) Terminal sends the five-byte header before any command data.
// (RULE_03) Procedure byte after header admits data; status after header ends command.
// (RULE_04) Case 3: after all data and processing, card returns two status bytes.
// (RULE_05) Terminal drops the trailing expected-length byte of case 4 commands.
// (RULE_06) Case 4 after data: more-data bytes if normal, else status only.
// (RULE_07) Terminal's follow-up length does not exceed the more-data length.
// (RULE_08) Terminal still fetches after case 4 warning or application status.
// (RULE_09) Other case 4 status ends it; the follow-up is a case 2 command.
// (RULE_10) More-data and wrong-length bytes only for cases 2 and 4, byte protocol.
// (RULE_11) Terminal resends header with length from wrong-length byte.
// (RULE_12) Case 2 length zero or too long: wrong-length bytes with available length.
// (RULE_13) Case 2 length equal: data under procedure byte, then status.
// (RULE_14) Case 2 length smaller: requested bytes then more-data with remainder.
// (RULE_15) Status replacing length control because of error is never normal completion.
// (RULE_16) Block protocol carries command and response fields unchanged.
// (RULE_17) Block protocol: data only with more-data, warning, application or normal status.
// (RULE_18) Long command or response spans chained blocks concatenated in order.
// (RULE_19) Chaining flag set means another block follows; clear means last block.
// (RULE_20) Status 9000 is normal completion; other status ends processing.
// (RULE_21) Status is two bytes, first then second, handled as one word.
// (RULE_22) Terminal keeps the latest header for resending.
`timescale 1ns/1ps
module apdu_transport_layer
    import apdu_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Protocol select, sampled at the start of each command
    input wire logic block_mode_in,
    // Byte stream from the terminal
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_block_end_in,
    input wire logic rx_chain_in,
    // Byte stream to the terminal
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    output logic tx_block_end_out,
    output logic tx_chain_out,
    input wire logic tx_ready_in,
    // Command toward the card application
    output logic hdr_valid_out,
    output logic [39:0] hdr_out,
    output logic cmd_valid_out,
    output logic [7:0] cmd_data_out,
    output logic cmd_last_out,
    // Decisions and response from the card application
    input wire logic app_go_in,
    input wire logic [1:0] app_case_in,
    input wire logic app_done_in,
    input wire logic [15:0] app_sw_in,
    input wire logic [8:0] app_len_in,
    input wire logic resp_valid_in,
    input wire logic [7:0] resp_data_in,
    output logic resp_ready_out
);

    xfer_state_e state_reg, state_next;
    logic t1_reg, t1_next;
    logic [1:0] case_reg, case_next;
    logic [7:0] hdr_reg [HDR_LEN], hdr_next [HDR_LEN];
    logic [2:0] hidx_reg, hidx_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [9:0] tot_reg, tot_next;
    logic [8:0] blk_reg, blk_next;
    logic [7:0] sw1_reg, sw1_next, sw2_reg, sw2_next;
    logic tx_valid_reg, tx_valid_next;
    logic [7:0] tx_data_reg, tx_data_next;
    logic tx_end_reg, tx_end_next, tx_chain_reg, tx_chain_next;
    logic hdr_valid_reg, hdr_valid_next;
    logic cmd_valid_reg, cmd_valid_next, cmd_last_reg, cmd_last_next;
    logic [7:0] cmd_data_reg, cmd_data_next;
    logic tx_free, load;
    logic [7:0] load_byte;
    logic [8:0] le, len_eff;
    logic sw_err;

    sw_class_if cls_if ();

    status_classifier u_cls (
        .st(cls_if.cls)
    );

    assign cls_if.sw = app_sw_in;
    assign tx_free = !tx_valid_reg || tx_ready_in;
    assign resp_ready_out = (state_reg == ST_RESP_DATA) && tx_free;

    // ****************************************
    // Outputs
    // ****************************************
    assign tx_valid_out = tx_valid_reg;
    assign tx_data_out = tx_data_reg;
    assign tx_block_end_out = tx_end_reg;
    assign tx_chain_out = tx_chain_reg;
    assign hdr_valid_out = hdr_valid_reg;
    assign hdr_out = {hdr_reg[0], hdr_reg[1], hdr_reg[2], hdr_reg[3], hdr_reg[4]};
    assign cmd_valid_out = cmd_valid_reg;
    assign cmd_data_out = cmd_data_reg;
    assign cmd_last_out = cmd_last_reg;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_next = state_reg;
        t1_next = t1_reg;
        case_next = case_reg;
        hdr_next = hdr_reg;
        hidx_next = hidx_reg;
        cnt_next = cnt_reg;
        tot_next = tot_reg;
        blk_next = blk_reg;
        sw1_next = sw1_reg;
        sw2_next = sw2_reg;
        hdr_valid_next = 1'b0;
        cmd_valid_next = 1'b0;
        cmd_last_next = 1'b0;
        cmd_data_next = cmd_data_reg;
        load = 1'b0;
        load_byte = 8'h00;
        // Expected length; a zero length byte counts as the largest
        le = (hdr_reg[HDR_P3_IDX] == 8'h00) ? LEN_ZERO_AS : {1'b0, hdr_reg[HDR_P3_IDX]};
        // (RULE_17) Drop data with disallowed status
        len_eff = cls_if.data_ok ? app_len_in : 9'h000;
        // (RULE_15) Error path never carries normal status
        sw_err = !cls_if.is_normal;
        case (state_reg)
            ST_IDLE: begin
                if (rx_valid_in) begin
                    t1_next = block_mode_in;
                    if (block_mode_in) begin
                        // (RULE_16) Block field passed upward unchanged
                        cmd_valid_next = 1'b1;
                        cmd_data_next = rx_data_in;
                        cmd_last_next = rx_block_end_in && !rx_chain_in;
                        state_next = (rx_block_end_in && !rx_chain_in) ? ST_PROCESS : ST_T1_RX;
                    end else begin
                        // (RULE_02) Header collected first
                        hdr_next[0] = rx_data_in;
                        hidx_next = 3'h1;
                        state_next = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (rx_valid_in) begin
                    hdr_next[hidx_reg] = rx_data_in;
                    hidx_next = hidx_reg + 3'h1;
                    if (hidx_reg == HDR_LAST_IDX) begin
                        hdr_valid_next = 1'b1;
                        state_next = ST_DECIDE;
                    end
                end
            end
            ST_DECIDE: begin
                if (app_go_in && (app_case_in == CASE_3 || app_case_in == CASE_4)) begin
                    // (RULE_03) Procedure byte admits command data
                    case_next = app_case_in;
                    cnt_next = le;
                    state_next = ST_ACK;
                end else if (app_done_in) begin
                    case_next = app_case_in;
                    sw1_next = app_sw_in[15:8];
                    sw2_next = app_sw_in[7:0];
                    state_next = ST_SW1;
                    // (RULE_09) Follow-up treated as case 2
                    // (RULE_10) Length control only for case 2 here
                    if (app_case_in == CASE_2 && !sw_err) begin
                        if (hdr_reg[HDR_P3_IDX] == 8'h00 || le > app_len_in) begin
                            // (RULE_12) Wrong length with available length
                            sw1_next = SW1_WRONG_LEN;
                            sw2_next = app_len_in[7:0];
                        end else if (le == app_len_in) begin
                            // (RULE_13) Full data then status
                            cnt_next = le;
                            state_next = ST_ACK;
                        end else begin
                            // (RULE_14) Partial data then remaining length
                            cnt_next = le;
                            sw1_next = SW1_MORE_DATA;
                            sw2_next = 8'(app_len_in - le);
                            state_next = ST_ACK;
                        end
                    end
                end
            end
            ST_ACK: begin
                if (tx_free) begin
                    load = 1'b1;
                    load_byte = hdr_reg[HDR_INS_IDX];
                    state_next = (case_reg == CASE_2) ? ST_RESP_DATA : ST_CMD_DATA;
                end
            end
            ST_CMD_DATA: begin
                if (rx_valid_in) begin
                    // (RULE_01) Command bytes forwarded unchanged
                    cmd_valid_next = 1'b1;
                    cmd_data_next = rx_data_in;
                    cnt_next = cnt_reg - 9'h001;
                    if (cnt_reg == 9'h001) begin
                        cmd_last_next = 1'b1;
                        state_next = ST_PROCESS;
                    end
                end
            end
            ST_T1_RX: begin
                if (rx_valid_in) begin
                    // (RULE_18) Chained fields concatenated in order
                    cmd_valid_next = 1'b1;
                    cmd_data_next = rx_data_in;
                    // (RULE_19) Clear chain flag closes the command
                    if (rx_block_end_in && !rx_chain_in) begin
                        cmd_last_next = 1'b1;
                        state_next = ST_PROCESS;
                    end
                end
            end
            ST_PROCESS: begin
                if (app_done_in) begin
                    sw1_next = app_sw_in[15:8];
                    sw2_next = app_sw_in[7:0];
                    state_next = ST_SW1;
                    if (t1_reg) begin
                        cnt_next = len_eff;
                        tot_next = {1'b0, len_eff} + STATUS_BYTES;
                        blk_next = 9'h000;
                        state_next = (len_eff != 9'h000) ? ST_RESP_DATA : ST_SW1;
                    end else if (case_reg == CASE_4 && cls_if.is_normal
                        && app_len_in != 9'h000) begin
                        // (RULE_06) Normal case 4 asks for retrieval
                        sw1_next = SW1_MORE_DATA;
                        sw2_next = app_len_in[7:0];
                    end
                    // (RULE_04) Otherwise status word alone
                end
            end
            ST_RESP_DATA: begin
                if (tx_free && resp_valid_in) begin
                    load = 1'b1;
                    load_byte = resp_data_in;
                    cnt_next = cnt_reg - 9'h001;
                    if (cnt_reg == 9'h001) begin
                        state_next = ST_SW1;
                    end
                end
            end
            ST_SW1: begin
                if (tx_free) begin
                    // (RULE_21) First status byte, then second
                    load = 1'b1;
                    load_byte = sw1_reg;
                    state_next = ST_SW2;
                end
            end
            ST_SW2: begin
                if (tx_free) begin
                    // (RULE_20) Status word ends the command
                    load = 1'b1;
                    load_byte = sw2_reg;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Transmit byte and block framing
    // ****************************************
    always_comb begin
        tx_valid_next = tx_valid_reg && !tx_ready_in;
        tx_data_next = tx_data_reg;
        tx_end_next = tx_end_reg;
        tx_chain_next = tx_chain_reg;
        if (load) begin
            tx_valid_next = 1'b1;
            tx_data_next = load_byte;
            tx_end_next = 1'b0;
            tx_chain_next = 1'b0;
            if (t1_reg && state_reg != ST_ACK) begin
                // (RULE_18) Split response into blocks of at most IFS_MAX
                tx_end_next = (tot_reg == 10'h001) || (blk_reg == IFS_MAX - 9'h001);
                // (RULE_19) Chain flag set on a block-end byte unless it is the final byte
                tx_chain_next = (tot_reg != 10'h001) && tx_end_next;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            t1_reg <= 1'b0;
            case_reg <= CASE_1;
            for (int i = 0; i < HDR_LEN; i++) begin
                hdr_reg[i] <= 8'h00;
            end
            hidx_reg <= 3'h0;
            cnt_reg <= 9'h000;
            tot_reg <= 10'h000;
            blk_reg <= 9'h000;
            sw1_reg <= 8'h00;
            sw2_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_end_reg <= 1'b0;
            tx_chain_reg <= 1'b0;
            hdr_valid_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_data_reg <= 8'h00;
            cmd_last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            t1_reg <= t1_next;
            case_reg <= case_next;
            hdr_reg <= hdr_next;
            hidx_reg <= hidx_next;
            cnt_reg <= cnt_next;
            tot_reg <= (load && t1_reg) ? tot_reg - 10'h001 : tot_next;
            blk_reg <= (load && t1_reg) ? (tx_end_next ? 9'h000 : blk_reg + 9'h001) : blk_next;
            sw1_reg <= sw1_next;
            sw2_reg <= sw2_next;
            tx_valid_reg <= tx_valid_next;
            tx_data_reg <= tx_data_next;
            tx_end_reg <= tx_end_next;
            tx_chain_reg <= tx_chain_next;
            hdr_valid_reg <= hdr_valid_next;
            cmd_valid_reg <= cmd_valid_next;
            cmd_data_reg <= cmd_data_next;
            cmd_last_reg <= cmd_last_next;
        end
    end

endmodule

// ### rtl/apdu_pkg.sv
// Shared constants and types for the card-side transport layer
package apdu_pkg;

    // ****************************************
    // Framing and coding constants
    // ****************************************
    localparam int HDR_LEN = 5;
    localparam logic [2:0] HDR_LAST_IDX = 3'h4;
    localparam logic [2:0] HDR_P3_IDX = 3'h4;
    localparam logic [2:0] HDR_INS_IDX = 3'h1;
    localparam logic [7:0] SW1_MORE_DATA = 8'h61;
    localparam logic [7:0] SW1_WRONG_LEN = 8'h6c;
    localparam logic [7:0] SW1_WARN_A = 8'h62;
    localparam logic [7:0] SW1_WARN_B = 8'h63;
    localparam logic [3:0] SW1_APP_NIBBLE = 4'h9;
    localparam logic [15:0] SW_NORMAL = 16'h9000;
    localparam logic [8:0] LEN_ZERO_AS = 9'h100;
    localparam logic [8:0] IFS_MAX = 9'h020;
    localparam logic [9:0] STATUS_BYTES = 10'h002;

    // ****************************************
    // Command cases
    // ****************************************
    localparam logic [1:0] CASE_1 = 2'h0;
    localparam logic [1:0] CASE_2 = 2'h1;
    localparam logic [1:0] CASE_3 = 2'h2;
    localparam logic [1:0] CASE_4 = 2'h3;

    // ****************************************
    // Control states
    // ****************************************
    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_HDR       = 10'h002,
        ST_DECIDE    = 10'h004,
        ST_ACK       = 10'h008,
        ST_CMD_DATA  = 10'h010,
        ST_PROCESS   = 10'h020,
        ST_RESP_DATA = 10'h040,
        ST_SW1       = 10'h080,
        ST_SW2       = 10'h100,
        ST_T1_RX     = 10'h200
    } xfer_state_e;

endpackage

// ### rtl/sw_class_if.sv
// Carrier between the transport core and its status classifier
`timescale 1ns/1ps
interface sw_class_if;
    logic [15:0] sw;
    logic is_normal;
    logic is_warning;
    logic is_app;
    logic data_ok;

    modport core (output sw, input is_normal, input is_warning, input is_app, input data_ok);
    modport cls (input sw, output is_normal, output is_warning, output is_app, output data_ok);
endinterface

// ### rtl/status_classifier.sv
// Classifies a status word into completion classes
`timescale 1ns/1ps
module status_classifier
    import apdu_pkg::*;
(
    // Status word and its classes
    sw_class_if.cls st
);

    always_comb begin
        st.is_normal = (st.sw == SW_NORMAL);
        st.is_warning = (st.sw[15:8] == SW1_WARN_A) || (st.sw[15:8] == SW1_WARN_B);
        st.is_app = (st.sw[15:12] == SW1_APP_NIBBLE) && (st.sw != SW_NORMAL);
        st.data_ok = st.is_normal || st.is_warning || st.is_app
            || (st.sw[15:8] == SW1_MORE_DATA);
    end

endmodule

// ### testbench/apdu_transport_layer_properties.sv
// Concurrent checks on the card-side transport layer ports
`timescale 1ns/1ps
module apdu_transport_layer_properties
    import apdu_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Terminal side
    input wire logic rx_valid_in,
    input wire logic tx_valid_out,
    input wire logic [7:0] tx_data_out,
    input wire logic tx_block_end_out,
    input wire logic tx_chain_out,
    input wire logic tx_ready_in,
    // Application side
    input wire logic hdr_valid_out,
    input wire logic [39:0] hdr_out,
    input wire logic cmd_valid_out,
    input wire logic cmd_last_out,
    input wire logic app_go_in,
    input wire logic [1:0] app_case_in,
    input wire logic app_done_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    hdr_pulse_a: assert property (hdr_valid_out |=> !hdr_valid_out)
        else $error("Header strobe too long");
    hdr_cause_a: assert property (hdr_valid_out |-> $past(rx_valid_in))
        else $error("Header strobe without byte");
    hdr_keep_a: assert property (!rx_valid_in |=> $stable(hdr_out))
        else $error("Header changed without strobe");
    tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
        $stable({tx_data_out, tx_block_end_out, tx_chain_out})) else $error("Tx byte dropped");
    chain_end_a: assert property (tx_chain_out |-> tx_block_end_out && tx_valid_out)
        else $error("Chain flag off block end");
    cmd_fwd_a: assert property (cmd_valid_out |-> $past(rx_valid_in))
        else $error("Command byte without input");
    last_ok_a: assert property (cmd_last_out |-> cmd_valid_out)
        else $error("Last marker without byte");
    go_ins_a: assert property (app_go_in && app_case_in[1] |-> ##[1:4] tx_valid_out)
        else $error("No procedure byte after go");
    done_sw_a: assert property (app_done_in |-> ##[1:8] tx_valid_out)
        else $error("No reply after done");
    cover property (hdr_valid_out);
    cover property (tx_chain_out && tx_ready_in);
    cover property (cmd_last_out);
    cover property (app_go_in && app_case_in == CASE_4);
endmodule

bind apdu_transport_layer apdu_transport_layer_properties chk (.clock_in, .rst_in,
    .rx_valid_in, .tx_valid_out, .tx_data_out, .tx_block_end_out, .tx_chain_out,
    .tx_ready_in, .hdr_valid_out, .hdr_out, .cmd_valid_out, .cmd_last_out, .app_go_in,
    .app_case_in, .app_done_in);

// ### testbench/terminal_model.sv
// Terminal model sending bytes and accepting card replies
`timescale 1ns/1ps
module terminal_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Bytes toward the card
    output logic rx_valid_out = 1'b0,
    output logic [7:0] rx_data_out = 8'h00,
    output logic rx_block_end_out = 1'b0,
    output logic rx_chain_out = 1'b0,
    // Acceptance of card bytes
    output logic tx_ready_out = 1'b0
);
    logic [39:0] last_hdr = 40'h0;
    always @(posedge clock_in) begin
        tx_ready_out <= !rst_in && ($urandom_range(3) != 0);
    end
    task automatic send(input logic [7:0] b, input logic e, input logic c);
        @(posedge clock_in);
        rx_valid_out <= 1'b1;
        rx_data_out <= b;
        rx_block_end_out <= e;
        rx_chain_out <= c;
        @(posedge clock_in);
        rx_valid_out <= 1'b0;
        rx_data_out <= ~b;
        rx_block_end_out <= ~e;
        rx_chain_out <= ~c;
    endtask
    task automatic send_hdr(input logic [39:0] h);
        last_hdr = h;
        for (int i = 4; i >= 0; i--) begin
            send(h[8*i +: 8], 1'b0, 1'b0);
        end
    endtask
    task automatic resend(input logic [7:0] p3);
        send_hdr({last_hdr[39:8], p3});
    endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the card-side transport layer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import apdu_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic block_mode_in = 1'b0;
    logic rx_valid_in, rx_block_end_in, rx_chain_in, tx_ready_in;
    logic [7:0] rx_data_in, tx_data_out, cmd_data_out;
    logic tx_valid_out, tx_block_end_out, tx_chain_out, hdr_valid_out;
    logic cmd_valid_out, cmd_last_out, resp_ready_out;
    logic [39:0] hdr_out;
    logic app_go_in = 1'b0;
    logic app_done_in = 1'b0;
    logic [1:0] app_case_in = 2'h0;
    logic [15:0] app_sw_in = 16'h0000;
    logic [8:0] app_len_in = 9'h000;
    logic resp_valid_in = 1'b0;
    logic [7:0] resp_data_in = 8'h00;
    logic [9:0] exp_tx[$];
    logic [8:0] exp_cmd[$];
    logic [39:0] exp_hdr[$];
    logic [9:0] t_tx;
    logic [8:0] t_cmd;
    logic [39:0] t_hdr;
    int err_total = 0;
    int n_tests = 0;

    always #2.5 clock_in = ~clock_in;

    apdu_transport_layer uut (.clock_in, .rst_in, .block_mode_in, .rx_valid_in, .rx_data_in,
        .rx_block_end_in, .rx_chain_in, .tx_valid_out, .tx_data_out, .tx_block_end_out,
        .tx_chain_out, .tx_ready_in, .hdr_valid_out, .hdr_out, .cmd_valid_out, .cmd_data_out,
        .cmd_last_out, .app_go_in, .app_case_in, .app_done_in, .app_sw_in, .app_len_in,
        .resp_valid_in, .resp_data_in, .resp_ready_out);
    terminal_model term (.clock_in, .rst_in, .rx_valid_out(rx_valid_in),
        .rx_data_out(rx_data_in), .rx_block_end_out(rx_block_end_in),
        .rx_chain_out(rx_chain_in), .tx_ready_out(tx_ready_in));

    // ****************************************
    // Output watcher
    // ****************************************
    always @(posedge clock_in) begin
        if (resp_valid_in && resp_ready_out) resp_data_in <= resp_data_in + 8'h01;
        if (tx_valid_out && tx_ready_in) begin
            t_tx = (exp_tx.size() != 0) ? exp_tx.pop_front() : 'x;
            `CHK("tx", t_tx, {tx_block_end_out, tx_chain_out, tx_data_out})
        end
        if (cmd_valid_out) begin
            t_cmd = (exp_cmd.size() != 0) ? exp_cmd.pop_front() : 'x;
            `CHK("cmd", t_cmd, {cmd_last_out, cmd_data_out})
        end
        if (hdr_valid_out) begin
            t_hdr = (exp_hdr.size() != 0) ? exp_hdr.pop_front() : 'x;
            `CHK("hdr", t_hdr, hdr_out)
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] b);
        exp_tx.push_back({2'b00, b});
    endtask
    task automatic settle();
        int k;
        k = 0;
        while ((exp_tx.size() + exp_cmd.size() + exp_hdr.size()) != 0 && k < 3000) begin
            @(posedge clock_in);
            k++;
        end
        if (k == 3000) `CHK("drain", 1'b0, 1'b1)
        repeat (3) @(posedge clock_in);
    endtask
    task automatic app(input logic go, input logic [1:0] cs, input logic [15:0] sw,
            input logic [8:0] ln);
        @(posedge clock_in);
        app_go_in <= go;
        app_done_in <= !go;
        app_case_in <= cs;
        app_sw_in <= sw;
        app_len_in <= ln;
        @(posedge clock_in);
        app_go_in <= 1'b0;
        app_done_in <= 1'b0;
    endtask
    task automatic header(input logic [7:0] p3);
        logic [39:0] h;
        h = {8'($urandom), 8'ha4, 8'($urandom), 8'($urandom), p3};
        exp_hdr.push_back(h);
        term.send_hdr(h);
        settle();
    endtask
    task automatic data_cmd(input logic [1:0] cs, input int n, input logic [15:0] sw,
            input logic [8:0] ln, input logic [15:0] res);
        logic [7:0] b;
        header(n[7:0]);
        put(8'ha4);
        app(1'b1, cs, 16'h0000, 9'h000);
        settle();
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            exp_cmd.push_back({i == n - 1, b});
            term.send(b, 1'b0, 1'b0);
        end
        settle();
        put(res[15:8]);
        put(res[7:0]);
        app(1'b0, cs, sw, ln);
        settle();
    endtask
    task automatic case2(input logic [7:0] p3, input logic [8:0] ln, input logic [15:0] sw);
        int le;
        le = (p3 == 8'h00) ? 256 : p3;
        if (sw != SW_NORMAL) begin
            put(sw[15:8]);
            put(sw[7:0]);
        end else if (p3 == 8'h00 || le > ln) begin
            put(SW1_WRONG_LEN);
            put(ln[7:0]);
        end else begin
            put(8'ha4);
            for (int k = 0; k < le; k++) put(resp_data_in + 8'(k));
            put(le < ln ? SW1_MORE_DATA : sw[15:8]);
            put(le < ln ? 8'(ln - le) : sw[7:0]);
        end
        app(1'b0, CASE_2, sw, ln);
        settle();
    endtask
    task automatic blk(input int n, input logic [15:0] sw, input logic [8:0] ln);
        int dl;
        logic [7:0] b;
        block_mode_in <= 1'b1;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            exp_cmd.push_back({i == n - 1, b});
            term.send(b, i % 32 == 31 || i == n - 1, i % 32 == 31 && i != n - 1);
        end
        settle();
        dl = (sw[15:12] == SW1_APP_NIBBLE || sw[15:8] inside {8'h61, 8'h62, 8'h63}) ? ln : 0;
        for (int i = 0; i < dl + 2; i++) begin
            b = (i < dl) ? resp_data_in + 8'(i) : ((i == dl) ? sw[15:8] : sw[7:0]);
            exp_tx.push_back({i % 32 == 31 || i == dl + 1, i % 32 == 31 && i != dl + 1, b});
        end
        app(1'b0, CASE_4, sw, ln);
        settle();
        block_mode_in <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        #(5ns * 60000);
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h1ce9));
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        resp_valid_in <= 1'b1;
        data_cmd(CASE_3, 1, SW_NORMAL, 9'h000, SW_NORMAL);
        data_cmd(CASE_3, 255, 16'h6a82, 9'h000, 16'h6a82);
        data_cmd(CASE_4, 3, SW_NORMAL, 9'h010, 16'h6110);
        header(8'h10);
        case2(8'h10, 9'h010, SW_NORMAL);
        data_cmd(CASE_4, 2, SW_NORMAL, 9'h100, 16'h6100);
        data_cmd(CASE_4, 4, 16'h6283, 9'h010, 16'h6283);
        header(8'h05);
        put(8'h6a);
        put(8'h82);
        app(1'b0, CASE_3, 16'h6a82, 9'h000);
        settle();
        header(8'h00);
        case2(8'h00, 9'h008, SW_NORMAL);
        exp_hdr.push_back({term.last_hdr[39:8], 8'h08});
        term.resend(8'h08);
        settle();
        case2(8'h08, 9'h008, SW_NORMAL);
        header(8'h10);
        case2(8'h10, 9'h008, SW_NORMAL);
        header(8'h04);
        case2(8'h04, 9'h009, SW_NORMAL);
        header(8'h04);
        case2(8'h04, 9'h009, 16'h6982);
        blk(3, SW_NORMAL, 9'h002);
        blk(40, SW_NORMAL, 9'h028);
        blk(4, 16'h6a82, 9'h005);
        blk(2, 16'h9100, 9'h003);
        complete_run();
    end
endmodule
